// >>> rtl/flash_host_defs.svh
// timing counts, command codes and pin-level constants for the flash host controller
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

`define CLK_PERIOD_NS 100
`define POWERUP_DELAY_MS 5
`define POWERUP_CYCLES ((`POWERUP_DELAY_MS * 1000000) / `CLK_PERIOD_NS)
`define GLITCH_NS 10
`define STROBE_CYCLES (((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 1)
`define POLL_LIMIT 16'hFFFF

`define UNLOCK1_ADDR 16'h5555
`define UNLOCK1_DATA 8'hAA
`define UNLOCK2_ADDR 16'h2AAA
`define UNLOCK2_DATA 8'h55
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_ID_ENTRY 8'h90
`define CMD_ID_EXIT 8'hF0
`define CMD_CHIP_ERASE 8'h10
`define CMD_PAGE_ERASE 8'h50
`define ID_MAKER_ADDR 16'h0000
`define ID_PART_ADDR 16'h0001
`define PAGE_MSB 15
`define PAGE_LSB 12

`define REG_CTRL 4'h0
`define REG_ADDR 4'h1
`define REG_WDATA 4'h2
`define REG_STATUS 4'h3
`define REG_RDATA 4'h4

`define OP_READ 3'h0
`define OP_PROGRAM 3'h1
`define OP_CHIP_ERASE 3'h2
`define OP_PAGE_ERASE 3'h3
`define OP_ID_ENTRY 3'h4
`define OP_ID_EXIT3 3'h5
`define OP_ID_EXIT1 3'h6

`endif

// >>> rtl/flash_host_pkg.sv
// types shared by the flash host controller
package flash_host_pkg;
  typedef enum logic [5:0] {
    ST_BOOT = 6'h01,
    ST_IDLE = 6'h02,
    ST_WRITE = 6'h04,
    ST_READ = 6'h08,
    ST_POLL = 6'h10,
    ST_GAP = 6'h20
  } host_state_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic is_read;
  } bus_step_t;
endpackage

// >>> rtl/flash_bus_cycle.sv
// one timed bus cycle on the flash pins: write or read, strobes held long enough
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_bus_cycle
  import flash_host_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic is_read,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] dq_in,
  output logic done_q,
  output logic [7:0] rdata_q,
  output logic ce_n_q,
  output logic oe_n_q,
  output logic we_n_q,
  output logic [15:0] addr_q,
  output logic [7:0] dq_out_q,
  output logic dq_oe_n_q
);
  logic [7:0] dq_s1_q;
  logic [7:0] dq_s2_q;
  logic [2:0] phase_q;
  logic [3:0] cnt_q;
  logic rd_q;

  ////////////////////////////////////////////////////////////////
  // data pin synchroniser
  always_ff @(posedge core_clk) begin
    dq_s1_q <= dq_in;
    dq_s2_q <= dq_s1_q;
  end

  ////////////////////////////////////////////////////////////////
  // phase: 0 idle, 1 setup, 2 strobe low, 3 strobe high, 4 sample wait
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase_q <= 3'h0;
      cnt_q <= 4'h0;
      rd_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      addr_q <= 16'h0000;
      dq_out_q <= 8'h00;
      dq_oe_n_q <= 1'b1;
    end else begin
      done_q <= 1'b0;
      case (phase_q)
        3'h0: begin
          if (start) begin
            rd_q <= is_read;
            addr_q <= addr; // address stable before either strobe falls
            dq_out_q <= wdata;
            dq_oe_n_q <= is_read;
            oe_n_q <= 1'b1; // oe high during writes
            phase_q <= 3'h1;
          end
        end
        3'h1: begin
          ce_n_q <= 1'b0;
          if (rd_q) begin
            oe_n_q <= 1'b0;
          end else begin
            we_n_q <= 1'b0; // write only with ce and we low, oe high
          end
          cnt_q <= 4'(`STROBE_CYCLES);
          phase_q <= 3'h2;
        end
        3'h2: begin
          // strobe held well past the glitch filter width
          if (cnt_q == 4'h1) begin
            if (rd_q) begin
              phase_q <= 3'h4;
              cnt_q <= 4'h3;
            end else begin
              we_n_q <= 1'b1; // data taken on this first rising edge
              phase_q <= 3'h3;
            end
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        3'h3: begin
          ce_n_q <= 1'b1;
          dq_oe_n_q <= 1'b1;
          done_q <= 1'b1;
          phase_q <= 3'h0;
        end
        3'h4: begin
          if (cnt_q == 4'h1) begin
            rdata_q <= dq_s2_q;
            oe_n_q <= 1'b1; // each read is a separate oe pulse
            ce_n_q <= 1'b1;
            done_q <= 1'b1;
            phase_q <= 3'h0;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          phase_q <= 3'h0;
        end
      endcase
    end
  end
endmodule

// >>> rtl/flash_host_ctrl.sv
// host controller that drives a byte-wide parallel flash through its pins
//
// Contract
// - write only with select and write strobe low and output gate high
// - identifier mode lasts until an exit sequence is written
// - byte program: two unlocks, set-up, then address and data
// - chip erase: unlocks, erase set-up, unlocks, chip erase command
// - page erase ends on poll bit one; poll inside the erased page
// - polling valid after the last write edge; poll inside erased pages
// - host re-reads after completion since other bits may be stale
// - page selected by top four address bits, sixteen 4 Kbyte pages
// - a single exit-code write at any address leaves identifier mode
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = `POWERUP_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_q,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out_q,
  output logic flash_dq_oe_n_q,
  output logic [15:0] flash_addr_q,
  output logic flash_ce_n_q,
  output logic flash_oe_n_q,
  output logic flash_we_n_q
);
  host_state_t state_q;
  logic [22:0] boot_cnt_q;
  logic [2:0] op_q;
  logic [15:0] op_addr_q;
  logic [7:0] op_data_q;
  logic [2:0] step_q;
  logic [2:0] nsteps;
  bus_step_t step;
  logic busy_q;
  logic fail_q;
  logic id_mode_q;
  logic [7:0] last_rd_q;
  logic [7:0] prev_rd_q;
  logic poll_first_q;
  logic [15:0] poll_cnt_q;
  logic cyc_done;
  logic [7:0] cyc_rdata;
  logic go;

  ////////////////////////////////////////////////////////////////
  // register port: ctrl write launches an operation
  assign go = reg_wr && (reg_addr == `REG_CTRL) && reg_wdata[0] && (state_q == ST_IDLE);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      op_q <= `OP_READ;
      op_addr_q <= 16'h0000;
      op_data_q <= 8'h00;
    end else begin
      if (reg_wr && state_q == ST_IDLE) begin
        if (reg_addr == `REG_CTRL) begin
          op_q <= reg_wdata[3:1];
        end else if (reg_addr == `REG_ADDR) begin
          op_addr_q <= reg_wdata;
        end else if (reg_addr == `REG_WDATA) begin
          op_data_q <= reg_wdata[7:0];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == `REG_CTRL) begin
        reg_rdata_q <= {12'h000, op_q, 1'b0};
      end else if (reg_addr == `REG_ADDR) begin
        reg_rdata_q <= op_addr_q;
      end else if (reg_addr == `REG_WDATA) begin
        reg_rdata_q <= {8'h00, op_data_q};
      end else if (reg_addr == `REG_STATUS) begin
        reg_rdata_q <= {12'h000, id_mode_q, fail_q, busy_q, state_q == ST_BOOT};
      end else if (reg_addr == `REG_RDATA) begin
        reg_rdata_q <= {8'h00, last_rd_q};
      end else begin
        reg_rdata_q <= 16'h0000;
      end
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////
  // command sequence table
  function automatic bus_step_t unlock(input logic [2:0] idx, input logic [7:0] code);
    bus_step_t s;
    s.is_read = 1'b0;
    s.addr = (idx == 3'h1) ? `UNLOCK2_ADDR : `UNLOCK1_ADDR;
    s.data = (idx == 3'h0) ? `UNLOCK1_DATA : (idx == 3'h1) ? `UNLOCK2_DATA : code;
    return s;
  endfunction

  always_comb begin
    nsteps = 3'h1;
    step = '{addr: op_addr_q, data: op_data_q, is_read: 1'b1};
    case (op_q)
      `OP_PROGRAM: begin
        nsteps = 3'h4;
        step = (step_q < 3'h3) ? unlock(step_q, `CMD_PROGRAM) :
               bus_step_t'{addr: op_addr_q, data: op_data_q, is_read: 1'b0};
      end
      `OP_CHIP_ERASE, `OP_PAGE_ERASE: begin
        nsteps = 3'h6;
        if (step_q < 3'h3) begin
          step = unlock(step_q, `CMD_ERASE_SETUP);
        end else if (step_q < 3'h5) begin
          step = unlock(step_q - 3'h3, 8'h00);
        end else if (op_q == `OP_CHIP_ERASE) begin
          step = '{addr: `UNLOCK1_ADDR, data: `CMD_CHIP_ERASE, is_read: 1'b0};
        end else begin
          // page picked by top four address bits
          step = '{addr: {op_addr_q[`PAGE_MSB:`PAGE_LSB], 12'h000},
                   data: `CMD_PAGE_ERASE, is_read: 1'b0};
        end
      end
      `OP_ID_ENTRY: begin
        nsteps = 3'h3;
        step = unlock(step_q, `CMD_ID_ENTRY);
      end
      `OP_ID_EXIT3: begin
        nsteps = 3'h3;
        step = unlock(step_q, `CMD_ID_EXIT);
      end
      `OP_ID_EXIT1: begin
        step = '{addr: op_addr_q, data: `CMD_ID_EXIT, is_read: 1'b0};
      end
      default: begin
        nsteps = 3'h1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // sequencer
  logic launch_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ST_BOOT;
      boot_cnt_q <= 23'h000000;
      step_q <= 3'h0;
      busy_q <= 1'b0;
      fail_q <= 1'b0;
      id_mode_q <= 1'b0; // device assumed in read mode at power-up
      last_rd_q <= 8'h00;
      prev_rd_q <= 8'h00;
      poll_first_q <= 1'b0;
      poll_cnt_q <= 16'h0000;
      launch_q <= 1'b0;
    end else begin
      launch_q <= 1'b0;
      case (state_q)
        ST_BOOT: begin
          // no command before the power-up delay
          if (boot_cnt_q == 23'(POWERUP_CYCLES - 1)) begin
            state_q <= ST_IDLE;
          end else begin
            boot_cnt_q <= boot_cnt_q + 23'h000001;
          end
        end
        ST_IDLE: begin
          if (go) begin
            step_q <= 3'h0;
            busy_q <= 1'b1;
            fail_q <= 1'b0;
            launch_q <= 1'b1;
            state_q <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (cyc_done) begin
            if (step.is_read) begin
              last_rd_q <= cyc_rdata; // id codes read at low byte 0 or 1
              busy_q <= 1'b0;
              state_q <= ST_GAP;
            end else if (step_q == nsteps - 3'h1) begin
              if (op_q == `OP_ID_ENTRY) begin
                id_mode_q <= 1'b1;
              end
              if (op_q == `OP_ID_EXIT3 || op_q == `OP_ID_EXIT1) begin
                id_mode_q <= 1'b0;
              end
              if (op_q == `OP_PROGRAM || op_q == `OP_CHIP_ERASE || op_q == `OP_PAGE_ERASE) begin
                // no command issued while the device is busy
                poll_first_q <= 1'b1;
                poll_cnt_q <= 16'h0000;
                launch_q <= 1'b1;
                state_q <= ST_POLL;
              end else begin
                busy_q <= 1'b0;
                state_q <= ST_GAP;
              end
            end else begin
              step_q <= step_q + 3'h1; // steps in fixed order
              launch_q <= 1'b1;
            end
          end
        end
        ST_POLL: begin
          // poll at the target address, inside the erased page
          if (cyc_done) begin
            prev_rd_q <= cyc_rdata;
            poll_first_q <= 1'b0;
            poll_cnt_q <= poll_cnt_q + 16'h0001;
            if (!poll_first_q && cyc_rdata[6] == prev_rd_q[6]) begin
              // toggling stopped: done, or program tried 0 to 1
              fail_q <= (op_q == `OP_PROGRAM) ? (cyc_rdata != op_data_q) :
                        (cyc_rdata[7] != 1'b1);
              state_q <= ST_READ; // re-read for valid data
              launch_q <= 1'b1;
            end else if (poll_cnt_q == `POLL_LIMIT) begin
              // status never settled: give up, report fail and re-read
              fail_q <= 1'b1;
              state_q <= ST_READ;
              launch_q <= 1'b1;
            end else begin
              launch_q <= 1'b1;
            end
          end
        end
        ST_READ: begin
          if (cyc_done) begin
            last_rd_q <= cyc_rdata;
            busy_q <= 1'b0;
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin cycle engine
  flash_bus_cycle u_cycle (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(launch_q),
    .is_read((state_q == ST_WRITE) ? step.is_read : 1'b1),
    .addr((state_q == ST_WRITE) ? step.addr : op_addr_q),
    .wdata(step.data),
    .dq_in(flash_dq_in),
    .done_q(cyc_done),
    .rdata_q(cyc_rdata),
    .ce_n_q(flash_ce_n_q),
    .oe_n_q(flash_oe_n_q),
    .we_n_q(flash_we_n_q),
    .addr_q(flash_addr_q),
    .dq_out_q(flash_dq_out_q),
    .dq_oe_n_q(flash_dq_oe_n_q)
  );
endmodule

// >>> tb/flash_host_ctrl_properties.sv
// checker on the flash host controller pins
`timescale 1ns/1ps
module flash_host_ctrl_properties #(
  parameter int unsigned POWERUP_CYCLES = 50000
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] flash_addr_q,
  input wire logic [7:0] flash_dq_out_q,
  input wire logic flash_dq_oe_n_q,
  input wire logic flash_ce_n_q,
  input wire logic flash_oe_n_q,
  input wire logic flash_we_n_q
);
  logic [31:0] boot_q;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      boot_q <= 32'h0;
    end else if (boot_q < POWERUP_CYCLES) begin
      boot_q <= boot_q + 32'h1;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_write_gated: assert property (!flash_we_n_q |-> flash_oe_n_q && !flash_ce_n_q)
    else $error("write strobe without select or with gate low");
  a_read_no_drive: assert property (!flash_oe_n_q |-> flash_we_n_q && flash_dq_oe_n_q)
    else $error("read overlaps a write");
  a_boot_no_write: assert property (boot_q < POWERUP_CYCLES |-> flash_we_n_q)
    else $error("write during power-up wait");
  a_we_pulse_wide: assert property ($fell(flash_we_n_q) |=> !flash_we_n_q)
    else $error("write strobe too narrow");
  a_write_data_on: assert property (!flash_we_n_q |-> !flash_dq_oe_n_q)
    else $error("data not driven during write");
  a_write_stable: assert property (!flash_we_n_q && !$past(flash_we_n_q)
    |-> $stable(flash_dq_out_q) && $stable(flash_addr_q))
    else $error("address or data moved during write");
  a_ce_outlasts_we: assert property ($rose(flash_we_n_q) |-> !flash_ce_n_q)
    else $error("select released before write strobe");
  a_poll_addr_held: assert property (!flash_oe_n_q && !$past(flash_oe_n_q)
    |-> $stable(flash_addr_q))
    else $error("address moved during read");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> flash_we_n_q && flash_ce_n_q)
    else $error("strobes active after reset");
  cover property ($rose(flash_we_n_q));
  cover property ($fell(flash_oe_n_q));
  cover property (boot_q == POWERUP_CYCLES && !flash_ce_n_q);
endmodule
bind flash_host_ctrl flash_host_ctrl_properties #(.POWERUP_CYCLES(POWERUP_CYCLES))
  flash_host_ctrl_properties_inst (.core_clk(core_clk), .rst_n(rst_n),
  .flash_addr_q(flash_addr_q), .flash_dq_out_q(flash_dq_out_q),
  .flash_dq_oe_n_q(flash_dq_oe_n_q), .flash_ce_n_q(flash_ce_n_q),
  .flash_oe_n_q(flash_oe_n_q), .flash_we_n_q(flash_we_n_q));

// >>> tb/flash_device_model.sv
// behavioural byte-wide flash answering the host pins
`timescale 1ns/1ps
module flash_device_model #(
  parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary value
  parameter logic [7:0] PART_ID = 8'h5E, // arbitrary value
  parameter int BUSY_READS = 4
) (
  input wire logic [15:0] flash_addr_q,
  input wire logic [7:0] flash_dq_out_q,
  input wire logic flash_ce_n_q,
  input wire logic flash_oe_n_q,
  input wire logic flash_we_n_q,
  output logic [7:0] flash_dq_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] rd;
  logic [7:0] last = 8'h00;
  logic [7:0] pdata = 8'h00;
  logic [2:0] step = 3'h0;
  logic id_mode = 1'b0;
  logic busy = 1'b0;
  logic erasing = 1'b0;
  logic tog = 1'b0;
  int left = 0;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  ////////////////////////////////////////
  task automatic start(input logic er, input int n);
    busy = 1'b1;
    erasing = er;
    left = n;
  endtask
  task automatic cmd(input logic [15:0] a, input logic [7:0] d);
    logic u1;
    logic u2;
    u1 = a == 16'h5555 && d == 8'hAA;
    u2 = a == 16'h2AAA && d == 8'h55;
    case (step)
      3'h0: begin
        step = u1 ? 3'h1 : 3'h0;
        if (d == 8'hF0) id_mode = 1'b0;
      end
      3'h1, 3'h4: step = u2 ? step + 3'h1 : 3'h0;
      3'h3: step = u1 ? 3'h4 : 3'h0;
      3'h2: begin
        step = a != 16'h5555 ? 3'h0 : d == 8'hA0 ? 3'h6 : d == 8'h80 ? 3'h3 : 3'h0;
        if (a == 16'h5555 && d == 8'h90) id_mode = 1'b1;
        if (a == 16'h5555 && d == 8'hF0) id_mode = 1'b0;
      end
      3'h5: begin
        step = 3'h0;
        if (a == 16'h5555 && d == 8'h10) begin
          foreach (mem[i]) mem[i] = 8'hFF;
          start(1'b1, BUSY_READS);
        end else if (d == 8'h50) begin
          for (int i = 0; i < 4096; i++) mem[{a[15:12], i[11:0]}] = 8'hFF;
          start(1'b1, BUSY_READS);
        end
      end
      default: begin
        step = 3'h0;
        start(1'b0, (mem[a] & d) == d ? BUSY_READS : 1);
        mem[a] = mem[a] & d;
        pdata = d;
      end
    endcase
  endtask
  always @(posedge flash_we_n_q) begin
    if (!flash_ce_n_q && flash_oe_n_q && !busy) begin
      cmd(flash_addr_q, flash_dq_out_q);
    end
  end
  always @(posedge flash_oe_n_q) begin
    last = rd;
    if (busy) begin
      tog = ~tog;
      left = left - 1;
      busy = left > 0;
    end
  end
  always @* begin
    rd = mem[flash_addr_q];
    if (id_mode) begin
      rd = flash_addr_q[7:0] == 8'h00 ? MAKER_ID : flash_addr_q[7:0] == 8'h01 ? PART_ID : 8'h00;
    end
    if (busy) begin
      rd = {erasing ? 1'b0 : ~pdata[7], tog, rd[5:0]};
    end
  end
  assign flash_dq_in = (!flash_ce_n_q && !flash_oe_n_q) ? rd : ~last;
endmodule

// >>> tb/testbench.sv
// self-checking bench for the flash host controller with a flash model
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module testbench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata_q;
  logic [15:0] flash_addr_q;
  logic [7:0] flash_dq_in;
  logic [7:0] flash_dq_out_q;
  logic flash_dq_oe_n_q;
  logic flash_ce_n_q;
  logic flash_oe_n_q;
  logic flash_we_n_q;
  int num_errors = 0;
  int total_checks = 0;
  always #50 core_clk = ~core_clk;
  flash_host_ctrl #(.POWERUP_CYCLES(20)) flash_host_ctrl_inst (.core_clk(core_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .flash_dq_in(flash_dq_in),
    .flash_dq_out_q(flash_dq_out_q), .flash_dq_oe_n_q(flash_dq_oe_n_q),
    .flash_addr_q(flash_addr_q), .flash_ce_n_q(flash_ce_n_q),
    .flash_oe_n_q(flash_oe_n_q), .flash_we_n_q(flash_we_n_q));
  flash_device_model #(.MAKER_ID(8'h3C), .PART_ID(8'h5E)) flash_device_model_inst (
    .flash_addr_q(flash_addr_q), .flash_dq_out_q(flash_dq_out_q),
    .flash_ce_n_q(flash_ce_n_q), .flash_oe_n_q(flash_oe_n_q),
    .flash_we_n_q(flash_we_n_q), .flash_dq_in(flash_dq_in));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  task automatic expect_reg(input string what, input logic [3:0] a, input logic [15:0] m,
    input logic [15:0] exp);
    logic [15:0] d;
    reg_read(a, d);
    check(what, exp, d & m);
  endtask
  task automatic expect_cell(input logic [15:0] a, input logic [7:0] exp);
    check("cell", {8'h00, exp}, {8'h00, flash_device_model_inst.mem[a]});
  endtask
  task automatic wait_idle(input int b);
    logic [15:0] s;
    for (int i = 0; i < 3000; i++) begin
      reg_read(`REG_STATUS, s);
      if (s[b] === 1'b0) return;
    end
    num_errors++;
    $display("CHECK FAILED status wait expected 0 seen %h", s);
    give_verdict();
  endtask
  task automatic run_op(input logic [2:0] op, input logic [15:0] a, input logic [7:0] d);
    reg_write(`REG_ADDR, a);
    reg_write(`REG_WDATA, {8'h00, d});
    reg_write(`REG_CTRL, {12'h000, op, 1'b1});
    repeat (3) @(posedge core_clk);
    wait_idle(1);
  endtask
  ////////////////////////////////////////
  task automatic test_boot();
    expect_reg("booting", `REG_STATUS, 16'h0001, 16'h0001);
    wait_idle(0);
    expect_reg("unmapped", 4'hF, 16'hFFFF, 16'h0000);
  endtask
  task automatic test_program();
    run_op(`OP_PROGRAM, 16'h1234, 8'h5A);
    expect_cell(16'h1234, 8'h5A);
    expect_reg("fail", `REG_STATUS, 16'h0006, 16'h0000);
    expect_reg("rdata", `REG_RDATA, 16'h00FF, 16'h005A);
    run_op(`OP_PROGRAM, 16'h1234, 8'hF0);
    expect_cell(16'h1234, 8'h50);
    expect_reg("fail", `REG_STATUS, 16'h0006, 16'h0004);
  endtask
  task automatic test_erase();
    run_op(`OP_PROGRAM, 16'h2345, 8'h00);
    run_op(`OP_PAGE_ERASE, 16'h1ABC, 8'h00);
    expect_cell(16'h1234, 8'hFF);
    expect_cell(16'h2345, 8'h00);
    expect_reg("fail", `REG_STATUS, 16'h0006, 16'h0000);
    expect_reg("rdata", `REG_RDATA, 16'h00FF, 16'h00FF);
    run_op(`OP_CHIP_ERASE, 16'h0000, 8'h00);
    expect_cell(16'h2345, 8'hFF);
    expect_reg("fail", `REG_STATUS, 16'h0006, 16'h0000);
  endtask
  task automatic test_ident();
    run_op(`OP_ID_ENTRY, 16'h0000, 8'h00);
    expect_reg("id mode", `REG_STATUS, 16'h0008, 16'h0008);
    run_op(`OP_READ, 16'h0000, 8'h00);
    expect_reg("maker", `REG_RDATA, 16'h00FF, 16'h003C);
    run_op(`OP_READ, 16'h0001, 8'h00);
    expect_reg("part", `REG_RDATA, 16'h00FF, 16'h005E);
    run_op(`OP_ID_EXIT1, 16'h7777, 8'h00);
    expect_reg("id mode", `REG_STATUS, 16'h0008, 16'h0000);
    run_op(`OP_READ, 16'h0001, 8'h00);
    expect_reg("array", `REG_RDATA, 16'h00FF, 16'h00FF);
    run_op(`OP_ID_ENTRY, 16'h0000, 8'h00);
    run_op(`OP_ID_EXIT3, 16'h0000, 8'h00);
    expect_reg("id mode", `REG_STATUS, 16'h0008, 16'h0000);
    check("exit", 16'h0000, {15'h0000, flash_device_model_inst.id_mode});
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    test_boot();
    test_program();
    test_erase();
    test_ident();
    give_verdict();
  end
endmodule
